/* File: hw/ppc_cfg.svh */
// Purpose: offsets, masks, reset values and counts of the port pin block
// Assumes: register index times four is the Avalon byte address
// Notes:   definitions only
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ----------------------------------------------------------------------
// register indexes
// ----------------------------------------------------------------------
`define PPC_IDX_H_DRIVE   6'h1b
`define PPC_IDX_H_PULL    6'h1c
`define PPC_IDX_H_POL     6'h1d
`define PPC_IDX_H_IEN     6'h1e
`define PPC_IDX_H_FLAG    6'h1f
`define PPC_IDX_J_DATA    6'h20
`define PPC_IDX_J_PIN     6'h21
`define PPC_IDX_J_DIR     6'h22
`define PPC_IDX_J_DRIVE   6'h23
`define PPC_IDX_J_PULL    6'h24
`define PPC_IDX_J_POL     6'h25
`define PPC_IDX_J_IEN     6'h26
`define PPC_IDX_J_FLAG    6'h27
`define PPC_IDX_L_DATA    6'h28
`define PPC_IDX_L_PIN     6'h29
`define PPC_IDX_CTRL      6'h2f

// ----------------------------------------------------------------------
// implemented bits, reset values, control fields
// ----------------------------------------------------------------------
`define PPC_MASK_H        8'h7f
`define PPC_MASK_J        8'hcf
`define PPC_MASK_L        8'h7f
`define PPC_MASK_CTRL     8'h07
`define PPC_RST_J_PULL    8'hc0
`define PPC_CTRL_TWO_WIRE 0
`define PPC_CTRL_MII      1
`define PPC_CTRL_LED      2

// ----------------------------------------------------------------------
// glitch filter: consecutive samples per level
// ----------------------------------------------------------------------
`define PPC_FILT_SAMPLES  3'd4

`endif

/* File: hw/ppc_pkg.sv */
// Purpose: types shared by the port pin block
// Assumes: nothing
// Notes:   constants live in ppc_cfg.svh
package ppc_pkg;

  // pad electrical settings
  typedef struct packed {
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } ppc_pull_s;

  // full pad drive: level, enable and settings
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    ppc_pull_s  cfg;
  } ppc_pad_s;

  typedef enum logic [0:0] {
    PPC_BUS_IDLE = 1'b0,
    PPC_BUS_ANS  = 1'b1
  } ppc_bus_e;

endpackage

/* File: hw/ppc_top.sv */
// Purpose: pin control for ports H (part), J and L (part)
// Assumes: pin inputs arrive synchronous to clk; one clock, 200 MHz
// Notes:   registers on an Avalon-MM slave with one wait state
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"

// How it works
// - reduced-drive bit lowers output strength; ignored while pin is input
// - port H pull enable acts only on inputs; all port H pulls off at reset
// - port J pulls on for bits 7:6, off for bits 3:0 after reset
// - polarity 1 means rising edge and pull-down; 0 falling and pull-up
// - per-pin interrupt enable; cleared bit masks that pin's flag
// - active edge on input pin sets that pin's flag
// - writing one clears a flag; writing zero leaves it
// - interrupt requested while any flag and its enable are both set
// - data read gives latch for outputs, pin level for inputs
// - pin-input register always returns pin levels; writes ignored
// - port J direction 1 output, 0 input; bits 7:6 and 3:0 only
// - pin reads may lag a direction change by up to three cycles
// - two-wire controller owns J7:6 and their direction when enabled
// - MII enabled makes J3:0 MDC, MDIO, CRS, COL under MAC direction
// - LED enable drives L4:0 as the five transceiver indicators
// - port H configuration registers implement bits 6:0 only
// - edge valid after four passive samples then four active samples
module ppc_top (
  input  wire logic               clk,
  input  wire logic               resetn,
  // avalon-mm slave
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [3:0]         byteenable,
  input  wire logic [31:0]        writedata,
  output var  logic [31:0]        readdata,
  output var  logic               waitrequest,
  // port h
  input  wire logic [6:0]         ph_in,
  input  wire logic [6:0]         ph_dir,
  output var  ppc_pkg::ppc_pull_s ph_pad,
  output var  logic               port_h_irq,
  // port j
  input  wire logic [7:0]         pj_in,
  output var  ppc_pkg::ppc_pad_s  pj_pad,
  output var  logic               port_j_irq,
  // port l
  input  wire logic [7:0]         pl_in,
  input  wire logic [6:0]         pl_dir,
  output var  logic [7:0]         pl_out,
  output var  logic [7:0]         pl_oe,
  // two-wire controller
  input  wire logic               two_wire_data_oe,
  input  wire logic               two_wire_clock_oe,
  output var  logic               two_wire_data_line,
  output var  logic               two_wire_clock_line,
  // ethernet mac unit management and status
  input  wire logic               mii_mdc,
  input  wire logic               mii_mdio_out,
  input  wire logic               mii_mdio_oe,
  output var  logic               mii_mdio_in,
  output var  logic               mii_crs,
  output var  logic               mii_col,
  // ethernet transceiver unit indicators, bit 4 down to bit 0:
  // collision, duplex, speed, link, activity
  input  wire logic [4:0]         phy_indicators
);
  import ppc_pkg::*;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0]  h_drive_q, h_pull_q, h_pol_q, h_ien_q, h_flag_q;
  logic [7:0]  j_data_q, j_dir_q, j_drive_q, j_pull_q, j_pol_q;
  logic [7:0]  j_ien_q, j_flag_q, l_data_q, ctrl_q;
  logic [22:0] sync1_q, sync2_q;
  ppc_bus_e    bus_q;
  logic [31:0] readdata_q;
  logic        waitrequest_q;

  // --------------------------------------------------------------------
  // pin synchroniser
  // --------------------------------------------------------------------
  // stage one feeds only stage two; everything else reads stage two
  // so pin reads trail a direction change by the pad flop and the two stages
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= 23'h000000;
      sync2_q <= 23'h000000;
    end else begin
      sync1_q <= {pl_in, pj_in, ph_in};
      sync2_q <= sync1_q;
    end
  end

  wire [6:0] ph_s = sync2_q[6:0];
  wire [7:0] pj_s = sync2_q[14:7];
  wire [7:0] pl_s = sync2_q[22:15];

  // --------------------------------------------------------------------
  // avalon decode
  // --------------------------------------------------------------------
  wire [5:0] idx     = address[7:2];
  wire       aligned = (address[1:0] == 2'b00);
  wire       wr_go   = write && (bus_q == PPC_BUS_ANS) && byteenable[0];
  wire [7:0] wd      = writedata[7:0];

  wire hit_h_drive = aligned && (idx == `PPC_IDX_H_DRIVE);
  wire hit_h_pull  = aligned && (idx == `PPC_IDX_H_PULL);
  wire hit_h_pol   = aligned && (idx == `PPC_IDX_H_POL);
  wire hit_h_ien   = aligned && (idx == `PPC_IDX_H_IEN);
  wire hit_h_flag  = aligned && (idx == `PPC_IDX_H_FLAG);
  wire hit_j_data  = aligned && (idx == `PPC_IDX_J_DATA);
  wire hit_j_pin   = aligned && (idx == `PPC_IDX_J_PIN);
  wire hit_j_dir   = aligned && (idx == `PPC_IDX_J_DIR);
  wire hit_j_drive = aligned && (idx == `PPC_IDX_J_DRIVE);
  wire hit_j_pull  = aligned && (idx == `PPC_IDX_J_PULL);
  wire hit_j_pol   = aligned && (idx == `PPC_IDX_J_POL);
  wire hit_j_ien   = aligned && (idx == `PPC_IDX_J_IEN);
  wire hit_j_flag  = aligned && (idx == `PPC_IDX_J_FLAG);
  wire hit_l_data  = aligned && (idx == `PPC_IDX_L_DATA);
  wire hit_l_pin   = aligned && (idx == `PPC_IDX_L_PIN);
  wire hit_ctrl    = aligned && (idx == `PPC_IDX_CTRL);

  // --------------------------------------------------------------------
  // data views
  // --------------------------------------------------------------------
  wire [7:0] pj_pin_v = pj_s & `PPC_MASK_J;
  wire [7:0] pl_pin_v = pl_s & `PPC_MASK_L;
  // latch for output pins, pin level for input pins
  wire [7:0] pj_data_v = ((j_data_q & j_dir_q) |
                          (pj_pin_v & ~j_dir_q)) & `PPC_MASK_J;
  wire [7:0] l_dir_v   = {1'b0, pl_dir};
  wire [7:0] pl_data_v = ((l_data_q & l_dir_v) |
                          (pl_pin_v & ~l_dir_v)) & `PPC_MASK_L;

  // read mux as an or of gated values; unmapped reads give zero
  wire [7:0] rd_mux =
      ({8{hit_h_drive}} & h_drive_q) | ({8{hit_h_pull}} & h_pull_q) |
      ({8{hit_h_pol}}   & h_pol_q)   | ({8{hit_h_ien}}  & h_ien_q)  |
      ({8{hit_h_flag}}  & h_flag_q)  | ({8{hit_j_data}} & pj_data_v) |
      ({8{hit_j_pin}}   & pj_pin_v)  | ({8{hit_j_dir}}  & j_dir_q)  |
      ({8{hit_j_drive}} & j_drive_q) | ({8{hit_j_pull}} & j_pull_q) |
      ({8{hit_j_pol}}   & j_pol_q)   | ({8{hit_j_ien}}  & j_ien_q)  |
      ({8{hit_j_flag}}  & j_flag_q)  | ({8{hit_l_data}} & pl_data_v) |
      ({8{hit_l_pin}}   & pl_pin_v)  | ({8{hit_ctrl}}   & ctrl_q);

  // --------------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer cycle
  // --------------------------------------------------------------------
  wire req = read || write;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_q         <= PPC_BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h00000000;
    end else begin
      case (bus_q)
        PPC_BUS_IDLE: begin
          if (req) begin
            bus_q         <= PPC_BUS_ANS;
            waitrequest_q <= 1'b0;
            readdata_q    <= {24'h000000, rd_mux};
          end
        end
        PPC_BUS_ANS: begin
          bus_q         <= PPC_BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
        default: begin
          bus_q         <= PPC_BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;

  // --------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------
  // masks keep unimplemented bits at zero whatever is written
  always_ff @(posedge clk) begin
    if (!resetn) begin
      h_drive_q <= 8'h00;
      h_pull_q  <= 8'h00;
      h_pol_q   <= 8'h00;
      h_ien_q   <= 8'h00;
      j_data_q  <= 8'h00;
      j_dir_q   <= 8'h00;
      j_drive_q <= 8'h00;
      j_pull_q  <= `PPC_RST_J_PULL;
      j_pol_q   <= 8'h00;
      j_ien_q   <= 8'h00;
      l_data_q  <= 8'h00;
      ctrl_q    <= 8'h00;
    end else if (wr_go) begin
      // new value lands at the edge ending the answer cycle
      if (hit_h_drive) h_drive_q <= wd & `PPC_MASK_H;
      if (hit_h_pull)  h_pull_q  <= wd & `PPC_MASK_H;
      if (hit_h_pol)   h_pol_q   <= wd & `PPC_MASK_H;
      if (hit_h_ien)   h_ien_q   <= wd & `PPC_MASK_H;
      if (hit_j_data)  j_data_q  <= wd & `PPC_MASK_J;
      if (hit_j_dir)   j_dir_q   <= wd & `PPC_MASK_J;
      if (hit_j_drive) j_drive_q <= wd & `PPC_MASK_J;
      if (hit_j_pull)  j_pull_q  <= wd & `PPC_MASK_J;
      if (hit_j_pol)   j_pol_q   <= wd & `PPC_MASK_J;
      if (hit_j_ien)   j_ien_q   <= wd & `PPC_MASK_J;
      if (hit_l_data)  l_data_q  <= wd & `PPC_MASK_L;
      if (hit_ctrl)    ctrl_q    <= wd & `PPC_MASK_CTRL;
    end
  end

  wire two_wire_en = ctrl_q[`PPC_CTRL_TWO_WIRE];
  wire mii_en      = ctrl_q[`PPC_CTRL_MII];
  wire phy_led_enable = ctrl_q[`PPC_CTRL_LED];

  // --------------------------------------------------------------------
  // edge filters, ports h and j as one 16-pin vector
  // --------------------------------------------------------------------
  wire [15:0] flt_lvl  = {pj_s, 1'b0, ph_s};
  wire [15:0] flt_pol  = {j_pol_q, h_pol_q};
  wire [15:0] flt_mask = {`PPC_MASK_J, `PPC_MASK_H};
  wire [15:0] flt_edge;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_filt
      logic [2:0] pas_cnt_q, act_cnt_q;
      logic       armed_q;
      // active level follows polarity: 1 high, 0 low
      wire act_lvl = (flt_lvl[g] == flt_pol[g]);
      wire act_full = (act_cnt_q == `PPC_FILT_SAMPLES - 3'd1);
      // the fourth active sample after an armed passive run fires once
      assign flt_edge[g] = flt_mask[g] && armed_q && act_lvl &&
                           act_full;
      // a polarity change does not reset the counts; an armed pin then
      // fires after four samples at the new active level
      always_ff @(posedge clk) begin
        if (!resetn) begin
          pas_cnt_q <= 3'd0;
          act_cnt_q <= 3'd0;
          armed_q   <= 1'b0;
        end else if (act_lvl) begin
          pas_cnt_q <= 3'd0;
          if (flt_edge[g]) begin
            armed_q   <= 1'b0;
            act_cnt_q <= 3'd0;
          end else if (armed_q && !act_full) begin
            act_cnt_q <= act_cnt_q + 3'd1;
          end
        end else begin
          act_cnt_q <= 3'd0;
          if (pas_cnt_q != `PPC_FILT_SAMPLES)
            pas_cnt_q <= pas_cnt_q + 3'd1;
          if (pas_cnt_q == `PPC_FILT_SAMPLES - 3'd1)
            armed_q <= 1'b1;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // interrupt flags and requests
  // --------------------------------------------------------------------
  // an edge in the clearing cycle survives: set wins over clear
  wire [7:0] h_clr = (wr_go && hit_h_flag) ? wd : 8'h00;
  wire [7:0] j_clr = (wr_go && hit_j_flag) ? wd : 8'h00;
  wire [7:0] h_flag_d = ((h_flag_q & ~h_clr) | flt_edge[7:0])
                        & `PPC_MASK_H;
  wire [7:0] j_flag_d = ((j_flag_q & ~j_clr) | flt_edge[15:8])
                        & `PPC_MASK_J;

  logic port_h_irq_q, port_j_irq_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      h_flag_q     <= 8'h00;
      j_flag_q     <= 8'h00;
      port_h_irq_q <= 1'b0;
      port_j_irq_q <= 1'b0;
    end else begin
      h_flag_q     <= h_flag_d;
      j_flag_q     <= j_flag_d;
      port_h_irq_q <= |(h_flag_q & h_ien_q);
      port_j_irq_q <= |(j_flag_q & j_ien_q);
    end
  end

  assign port_h_irq = port_h_irq_q;
  assign port_j_irq = port_j_irq_q;

  // --------------------------------------------------------------------
  // port j pin muxing
  // --------------------------------------------------------------------
  // two-wire lines are open drain: drive low only when the controller
  // enables them
  wire [7:0] tw_oe  = {two_wire_data_oe, two_wire_clock_oe, 6'h00};
  wire [7:0] mii_oe = {4'h0, 1'b1, mii_mdio_oe, 2'b00};
  wire [7:0] mii_o  = {4'h0, mii_mdc, mii_mdio_out, 2'b00};
  wire [7:0] sel_tw  = two_wire_en ? 8'hc0 : 8'h00;
  wire [7:0] sel_mii = mii_en ? 8'h0f : 8'h00;
  wire [7:0] sel_gp  = ~(sel_tw | sel_mii) & `PPC_MASK_J;

  wire [7:0] pj_oe_d = (sel_gp & j_dir_q) | (sel_tw & tw_oe) |
                       (sel_mii & mii_oe);
  wire [7:0] pj_out_d = (sel_gp & j_data_q) | (sel_mii & mii_o);

  ppc_pad_s pj_pad_d, pj_pad_q;
  always_comb begin
    pj_pad_d.out           = pj_out_d;
    pj_pad_d.oe            = pj_oe_d;
    // strength only matters while the pad drives
    pj_pad_d.cfg.reduced   = j_drive_q & pj_oe_d;
    // pulls only on inputs; polarity picks down (1) or up (0)
    pj_pad_d.cfg.pull_en   = j_pull_q & ~pj_oe_d & `PPC_MASK_J;
    pj_pad_d.cfg.pull_down = j_pol_q & `PPC_MASK_J;
  end

  // --------------------------------------------------------------------
  // port h pad settings and port l muxing
  // --------------------------------------------------------------------
  ppc_pull_s ph_pad_d, ph_pad_q;
  wire [7:0] ph_dir_v = {1'b0, ph_dir};
  always_comb begin
    ph_pad_d.reduced   = h_drive_q & ph_dir_v;
    ph_pad_d.pull_en   = h_pull_q & ~ph_dir_v;
    ph_pad_d.pull_down = h_pol_q;
  end

  wire [7:0] sel_led  = phy_led_enable ? 8'h1f : 8'h00;
  wire [7:0] led_v    = {3'b000, phy_indicators};
  wire [7:0] pl_out_d = (sel_led & led_v) | (~sel_led & l_data_q);
  wire [7:0] pl_oe_d  = sel_led | (~sel_led & l_dir_v);

  // --------------------------------------------------------------------
  // output flops
  // --------------------------------------------------------------------
  logic [7:0] pl_out_q, pl_oe_q;
  logic       tw_d_q, tw_c_q, mdio_q, crs_q, col_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pj_pad_q <= '0;
      ph_pad_q <= '0;
      pl_out_q <= 8'h00;
      pl_oe_q  <= 8'h00;
      tw_d_q   <= 1'b0;
      tw_c_q   <= 1'b0;
      mdio_q   <= 1'b0;
      crs_q    <= 1'b0;
      col_q    <= 1'b0;
    end else begin
      pj_pad_q <= pj_pad_d;
      ph_pad_q <= ph_pad_d;
      pl_out_q <= pl_out_d;
      pl_oe_q  <= pl_oe_d;
      tw_d_q   <= pj_s[7];
      tw_c_q   <= pj_s[6];
      mdio_q   <= pj_s[2];
      crs_q    <= pj_s[1];
      col_q    <= pj_s[0];
    end
  end

  assign pj_pad              = pj_pad_q;
  assign ph_pad              = ph_pad_q;
  assign pl_out              = pl_out_q;
  assign pl_oe               = pl_oe_q;
  assign two_wire_data_line  = tw_d_q;
  assign two_wire_clock_line = tw_c_q;
  assign mii_mdio_in         = mdio_q;
  assign mii_crs             = crs_q;
  assign mii_col             = col_q;

endmodule // ppc_top
`default_nettype wire

/* File: tb/ppc_top_monitor.sv */
// Purpose: bus handshake and pad sanity checks on the port pin block
// Assumes: sees only ports of ppc_top, one clock domain
// Notes:   attached by the bind after the module
`timescale 1ns/1ps
`default_nettype none
module ppc_top_monitor (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire logic [6:0]         ph_dir,
  input wire ppc_pkg::ppc_pull_s ph_pad,
  input wire ppc_pkg::ppc_pad_s  pj_pad,
  input wire logic               port_h_irq,
  input wire logic               port_j_irq
);
  import ppc_pkg::*;
  // ----------------------------------------------------------------------
  // checks, all on clk and its reset
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // answer lasts one cycle, so a held request cannot be taken twice
  a_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_bound: assert property ((read || write) && waitrequest
    |-> ##[1:2] !waitrequest)
    else $error("request not answered in time");
  a_answer_cause: assert property (!waitrequest
    |-> $past(read || write))
    else $error("answer without a request");
  a_upper_zero: assert property (!waitrequest
    |-> readdata[31:8] == 24'h0)
    else $error("readdata upper lanes not zero");
  a_h_unimpl: assert property (
    {ph_pad.reduced[7], ph_pad.pull_en[7], ph_pad.pull_down[7]} == 3'h0)
    else $error("port h bit 7 driven");
  a_j_unimpl: assert property (pj_pad.oe[5:4] == 2'h0
    && pj_pad.cfg.pull_en[5:4] == 2'h0)
    else $error("port j bits 5:4 driven");
  // direction stable for a cycle, so registered pad must have caught up
  a_h_pull_input: assert property ($past(ph_dir) == ph_dir
    |-> (ph_pad.pull_en[6:0] & ph_dir) == 7'h0)
    else $error("port h pull on an output");
  a_reset_quiet: assert property ($rose(resetn) |-> waitrequest
    && !port_h_irq && !port_j_irq && ph_pad.pull_en == 8'h0)
    else $error("outputs not quiet after reset");
endmodule // ppc_top_monitor

bind ppc_top ppc_top_monitor u_mon (
  .clk(clk), .resetn(resetn), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .ph_dir(ph_dir),
  .ph_pad(ph_pad), .pj_pad(pj_pad), .port_h_irq(port_h_irq),
  .port_j_irq(port_j_irq)
);
`default_nettype wire

/* File: tb/ppc_pin_model.sv */
// Purpose: port j pad ring with pulls and an outside driver
// Assumes: ext_en beats the pad, which fakes a shorted output
// Notes:   a released line without pull shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model (
  input  wire logic              clk,
  input  wire ppc_pkg::ppc_pad_s pad,
  input  wire logic [7:0]        ext,
  input  wire logic [7:0]        ext_en,
  output var  logic [7:0]        pin
);
  import ppc_pkg::*;
  logic [7:0] last_q = 8'h00;

  // ----------------------------------------------------------------------
  // level resolution per pin
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i]) pin[i] = ext[i];
      else if (pad.oe[i]) pin[i] = pad.out[i];
      else if (pad.cfg.pull_en[i]) pin[i] = !pad.cfg.pull_down[i];
      else pin[i] = !last_q[i]; // float: never hold a stale level
    end
  end

  // last level, for the floating case
  always_ff @(posedge clk) last_q <= pin;
endmodule // ppc_pin_model
`default_nettype wire

/* File: tb/test_port_pin_control_hjl.sv */
// Purpose: self-checking bench of the port pin block
// Assumes: Avalon answer after one wait cycle; pins driven at clock edges
// Notes:   register table first, then hand-written pin and flag cases
`timescale 1ns/1ps
`default_nettype none
`include "ppc_cfg.svh"
module test_port_pin_control_hjl;
  import ppc_pkg::*;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wd;
    logic [7:0] rst;
    logic [7:0] exp;
  } ppc_row_s;
  logic       clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
  logic       waitrequest, port_h_irq, port_j_irq, tw_d_oe = 1'b0;
  logic       tw_c_oe = 1'b0, mdc = 1'b0, tw_data, tw_clock;
  logic       mdio_in, crs, col;
  logic [7:0] address = 8'h00, pj_in, pl_out, pl_oe, ext = 8'h00;
  logic [7:0] ext_en = 8'hc3;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata;
  logic [6:0] ph_in = 7'h00, ph_dir = 7'h00;
  logic [4:0] phy_ind = 5'h00;
  ppc_pull_s  ph_pad;
  ppc_pad_s   pj_pad;
  int         err_count = 0, cmp_count = 0;
  ppc_row_s   rows [12] = '{
    '{`PPC_IDX_H_DRIVE, 8'hff, 8'h00, 8'h7f}, '{`PPC_IDX_H_PULL, 8'hff,
    8'h00, 8'h7f}, '{`PPC_IDX_H_POL, 8'hff, 8'h00, 8'h7f},
    '{`PPC_IDX_H_IEN, 8'hff, 8'h00, 8'h7f}, '{`PPC_IDX_J_DIR, 8'hff,
    8'h00, 8'hcf}, '{`PPC_IDX_J_DRIVE, 8'hff, 8'h00, 8'hcf},
    '{`PPC_IDX_J_PULL, 8'h00, 8'hc0, 8'h00}, '{`PPC_IDX_J_POL, 8'hff,
    8'h00, 8'hcf}, '{`PPC_IDX_J_IEN, 8'hff, 8'h00, 8'hcf},
    '{`PPC_IDX_L_DATA, 8'hff, 8'h00, 8'h00}, '{`PPC_IDX_L_PIN, 8'hff,
    8'h00, 8'h00}, '{6'h30, 8'hff, 8'h00, 8'h00}};

  always #2.5 clk = !clk;

  ppc_top u_dut (.clk(clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ph_in(ph_in), .ph_dir(ph_dir), .ph_pad(ph_pad),
    .port_h_irq(port_h_irq), .pj_in(pj_in), .pj_pad(pj_pad),
    .port_j_irq(port_j_irq), .pl_in(8'h00), .pl_dir(7'h00),
    .pl_out(pl_out), .pl_oe(pl_oe), .two_wire_data_oe(tw_d_oe),
    .two_wire_clock_oe(tw_c_oe), .two_wire_data_line(tw_data),
    .two_wire_clock_line(tw_clock), .mii_mdc(mdc), .mii_mdio_out(1'b0),
    .mii_mdio_oe(1'b0), .mii_mdio_in(mdio_in), .mii_crs(crs),
    .mii_col(col), .phy_indicators(phy_ind));
  ppc_pin_model u_pins (.clk(clk), .pad(pj_pad), .ext(ext),
    .ext_en(ext_en), .pin(pj_in));

  // ----------------------------------------------------------------------
  // bus master, compare and closing
  // ----------------------------------------------------------------------
  task automatic bus(input logic is_wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    address   <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    write     <= is_wr;
    read      <= !is_wr;
    @(posedge clk);
    // only the watchdog ends a wait that never gets an answer
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] idx,
                        input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(nm, {24'h0, d}, {24'h0, exp});
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, about thirty times the expected run
  initial begin
    repeat (8000) @(posedge clk);
    err_count++;
    results();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      rd_chk("reset value", rows[i].idx, rows[i].rst);
      wr(rows[i].idx, rows[i].wd);
      rd_chk("written value", rows[i].idx, rows[i].exp);
    end
    $display("test register table done");
    ph_dir <= 7'h0f;
    repeat (3) @(posedge clk);
    chk("port h pull", ph_pad.pull_en, 8'h70);
    byteenable <= 4'h0;
    wr(`PPC_IDX_H_IEN, 8'h00);
    byteenable <= 4'hf;
    rd_chk("masked write", `PPC_IDX_H_IEN, 8'h7f);
    wr(`PPC_IDX_H_FLAG, 8'h7f);
    ph_in <= 7'h40;
    repeat (10) @(posedge clk);
    rd_chk("port h flag", `PPC_IDX_H_FLAG, 8'h40);
    chk("port h irq", port_h_irq, 32'h1);
    wr(`PPC_IDX_H_FLAG, 8'h7f);
    rd_chk("port h cleared", `PPC_IDX_H_FLAG, 8'h00);
    $display("test port h done");
    // shorted output on bit 3 shows latch against pin level
    wr(`PPC_IDX_J_DIR, 8'h0c);
    wr(`PPC_IDX_J_DATA, 8'hac);
    ext    <= 8'h82;
    ext_en <= 8'hcb;
    repeat (4) @(posedge clk);
    rd_chk("data read", `PPC_IDX_J_DATA, 8'h8e);
    wr(`PPC_IDX_J_PIN, 8'h00);
    rd_chk("pin read", `PPC_IDX_J_PIN, 8'h86);
    $display("test data and pins done");
    wr(`PPC_IDX_J_POL, 8'h02);
    wr(`PPC_IDX_J_IEN, 8'h01);
    ext <= 8'h81;
    repeat (10) @(posedge clk);
    wr(`PPC_IDX_J_FLAG, 8'hff);
    ext <= 8'h82;
    repeat (10) @(posedge clk);
    rd_chk("edge flags", `PPC_IDX_J_FLAG, 8'h03);
    chk("port j irq", port_j_irq, 32'h1);
    wr(`PPC_IDX_J_FLAG, 8'h02);
    rd_chk("one cleared", `PPC_IDX_J_FLAG, 8'h01);
    wr(`PPC_IDX_J_IEN, 8'h00);
    repeat (3) @(posedge clk);
    chk("masked irq", port_j_irq, 32'h0);
    ext <= 8'h83;
    repeat (8) @(posedge clk);
    wr(`PPC_IDX_J_FLAG, 8'h01);
    ext <= 8'h82;
    repeat (3) @(posedge clk);
    ext <= 8'h83;
    repeat (10) @(posedge clk);
    rd_chk("short pulse", `PPC_IDX_J_FLAG, 8'h00);
    ext <= 8'h82;
    repeat (10) @(posedge clk);
    rd_chk("long pulse", `PPC_IDX_J_FLAG, 8'h01);
    $display("test port j edges done");
    wr(`PPC_IDX_J_DIR, 8'h00);
    ext_en  <= 8'h87;
    mdc     <= 1'b1;
    tw_c_oe <= 1'b1;
    phy_ind <= 5'h15;
    wr(`PPC_IDX_CTRL, 8'h07);
    repeat (6) @(posedge clk);
    chk("clock line in", tw_clock, 32'h0);
    chk("mii inputs", {mdio_in, crs, col}, 3'b010);
    chk("clock line drive", {pj_pad.oe[6], pj_pad.out[6]}, 2'b10);
    chk("data line input", tw_data, 32'h1);
    chk("mdc drive", {pj_pad.oe[3], pj_pad.out[3]}, 2'b11);
    chk("indicators", {pl_oe[4:0], pl_out[4:0]}, 10'h3f5);
    $display("test overrides done");
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("pull after reset", `PPC_IDX_J_PULL, 8'hc0);
    rd_chk("control after reset", `PPC_IDX_CTRL, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule // test_port_pin_control_hjl
`default_nettype wire
